// File: rtl/pmi_consts.svh
`ifndef PMI_CONSTS_SVH
`define PMI_CONSTS_SVH
// register byte offsets
`define PMI_OFF_CONTROL   8'h00
`define PMI_OFF_PATTERN   8'h04
`define PMI_OFF_MASK      8'h08
`define PMI_OFF_STATUS    8'h0C
`define PMI_OFF_IRQ_MASK  8'h10
// control field positions
`define PMI_CTL_FLAG      0
`define PMI_CTL_SENSE     1
`define PMI_CTL_ENABLE    2
`define PMI_CTL_IRQ_EN    3
// reset values
`define PMI_PATTERN_RST   8'hFF
`define PMI_MASK_RST      8'h00
`define PMI_CONTROL_RST   4'h0
`define PMI_IRQ_MASK_RST  2'h0
// least persistence: more than six cpu clocks
`define PMI_HOLD_CYCLES   6
`endif

// File: rtl/pmi_pkg.sv
package pmi_pkg;
	// match qualifier states
	typedef enum logic [2:0] {
		st_idle  = 3'b001,
		st_count = 3'b010,
		st_hit   = 3'b100
	} qual_state_t;
endpackage

// File: rtl/pmi_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module pmi_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta;       // first stage, read only by second
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	// next values
	always_comb begin
		next_meta = i_async;
		next_sync = meta;
	end

	// registers
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			meta   <= '0;
			o_sync <= '0;
		end else begin
			meta   <= next_meta;
			o_sync <= next_sync;
		end
	end
endmodule

// File: rtl/pmi_qualify.sv
`timescale 1ns/1ps
`include "pmi_consts.svh"
// persistence filter: pulses once a level holds longer than HOLD cycles
module pmi_qualify
	import pmi_pkg::*;
#(
	parameter int HOLD = `PMI_HOLD_CYCLES
) (
	input  wire logic i_core_clk,
	input  wire logic i_reset,
	input  wire logic i_cond,
	output logic      o_hit
);
	qual_state_t state;       // current state
	qual_state_t next_state;
	logic [7:0]  count;       // cycles the condition has held
	logic [7:0]  next_count;

	// next state; hit fires once per continuous match
	always_comb begin
		next_state = state;
		next_count = count;
		o_hit      = 1'b0;
		case (state)
			st_idle: begin
				next_count = 8'h01;
				if (i_cond) begin
					next_state = st_count;
				end
			end
			st_count: begin
				if (!i_cond) begin
					next_state = st_idle; // short match dropped
				end else if (count > 8'(HOLD)) begin
					o_hit      = 1'b1; // held more than HOLD clocks
					next_state = st_hit;
				end else begin
					next_count = count + 8'h01;
				end
			end
			st_hit: begin
				if (!i_cond) begin
					next_state = st_idle;
				end
			end
			default: next_state = st_idle;
		endcase
	end

	// registers
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			state <= st_idle;
			count <= 8'h00;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end
endmodule

// File: rtl/port_match_irq_unit.sv
`timescale 1ns/1ps
`include "pmi_consts.svh"
module port_match_irq_unit
	import pmi_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_reset,
	input  wire logic             i_psel,
	input  wire logic             i_penable,
	input  wire logic             i_pwrite,
	input  wire logic [7:0]       i_paddr,
	input  wire logic [31:0]      i_pwdata,
	output logic      [31:0]      o_prdata,
	output logic                  o_pready,
	output logic                  o_pslverr,
	input  wire logic [WIDTH-1:0] i_port_pins,
	output logic                  o_match_irq,
	output logic                  o_wake,
	output logic                  o_irq
);
	logic [WIDTH-1:0] match_pattern;        // compare value
	logic [WIDTH-1:0] next_match_pattern;
	logic [WIDTH-1:0] pin_match_mask;       // 1 = pin takes part
	logic [WIDTH-1:0] next_pin_match_mask;
	logic [3:0]       match_control;        // flag, sense, enable, irq enable
	logic [3:0]       next_match_control;
	logic [1:0]       irq_status;           // sticky: 0 match, 1 wake
	logic [1:0]       next_irq_status;
	logic [1:0]       irq_mask;             // 1 = event drives o_irq
	logic [1:0]       next_irq_mask;
	logic [31:0]      next_prdata;
	logic [31:0]      prdata;               // read word, stands until next read
	logic             ack;                  // access seen, ready this cycle
	logic             next_ack;
	logic             access;               // apb access phase, any offset
	logic             capture;              // first access cycle of a read
	logic [WIDTH-1:0] port_sync;            // synchronised port levels
	logic             port_equal;           // unmasked bits equal pattern
	logic             cond;                 // selected comparison true
	logic             hit;                  // qualified match pulse
	logic             wr;                   // write strobe
	logic             rd;                   // read strobe
	logic             addr_ok;              // mapped address
	logic             match_flag;
	logic             compare_sense_select;
	logic             unit_enable;
	logic             flag_irq_enable;

	assign match_flag           = match_control[`PMI_CTL_FLAG];
	assign compare_sense_select = match_control[`PMI_CTL_SENSE];
	assign unit_enable          = match_control[`PMI_CTL_ENABLE];
	assign flag_irq_enable      = match_control[`PMI_CTL_IRQ_EN];

	// pins come from outside, two flops before any logic
	pmi_sync #(.WIDTH(WIDTH)) u_sync (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_async    (i_port_pins),
		.o_sync     (port_sync)
	);

	// comparison; with all-ones pattern and not-equal any unmasked low key hits
	always_comb begin
		port_equal = ((port_sync ^ match_pattern) & pin_match_mask) == '0;
		cond = unit_enable && (compare_sense_select ? !port_equal : port_equal);
	end

	// persistence filter on the cpu clock; short glitches never set the flag
	pmi_qualify #(.HOLD(`PMI_HOLD_CYCLES)) u_qual (
		.i_core_clk (i_core_clk),
		.i_reset    (i_reset),
		.i_cond     (cond),
		.o_hit      (hit)
	);

	// apb decode: one wait state, so read data can leave from a flop;
	// error only on unmapped offsets, given together with ready
	always_comb begin
		addr_ok = (i_paddr == `PMI_OFF_CONTROL) || (i_paddr == `PMI_OFF_PATTERN)
			|| (i_paddr == `PMI_OFF_MASK) || (i_paddr == `PMI_OFF_STATUS)
			|| (i_paddr == `PMI_OFF_IRQ_MASK);
		access    = i_psel && i_penable;         // access phase, any offset
		capture   = access && !ack && !i_pwrite; // read word sampled here
		next_ack  = access && !ack;              // ready follows one cycle later
		// writes and read side effects land only on the ready edge
		wr        = access && ack && i_pwrite && addr_ok;
		rd        = access && ack && !i_pwrite && addr_ok;
		o_pready  = ack;
		o_pslverr = access && ack && !addr_ok;
	end

	// register next values
	always_comb begin
		next_match_pattern  = match_pattern;
		next_pin_match_mask = pin_match_mask;
		next_match_control  = match_control;
		next_irq_mask       = irq_mask;
		next_irq_status     = irq_status;
		if (wr && i_paddr == `PMI_OFF_PATTERN) begin
			next_match_pattern = i_pwdata[WIDTH-1:0];
		end
		if (wr && i_paddr == `PMI_OFF_MASK) begin
			next_pin_match_mask = i_pwdata[WIDTH-1:0];
		end
		if (wr && i_paddr == `PMI_OFF_IRQ_MASK) begin
			next_irq_mask = i_pwdata[1:0];
		end
		if (wr && i_paddr == `PMI_OFF_CONTROL) begin
			// flag can only be cleared by writing zero, never set by software
			next_match_control[3:1] = i_pwdata[3:1];
			if (!i_pwdata[`PMI_CTL_FLAG]) begin
				next_match_control[`PMI_CTL_FLAG] = 1'b0;
			end
		end
		// hardware set beats a simultaneous software clear
		if (hit) begin
			next_match_control[`PMI_CTL_FLAG] = 1'b1;
		end
		// status clears on read, new events win over the clear; only the bits
		// the reader was shown are cleared, so an event in the wait state stays
		if (rd && i_paddr == `PMI_OFF_STATUS) begin
			next_irq_status = irq_status & ~prdata[1:0];
		end
		if (hit) begin
			next_irq_status[0] = 1'b1;
		end
		if (hit && flag_irq_enable) begin
			next_irq_status[1] = 1'b1;
		end
	end

	// read mux; the word is caught on the first access edge and then stands
	always_comb begin
		next_prdata = prdata; // hold between reads
		if (capture) begin
			next_prdata = 32'h0000_0000; // unused upper bits read zero
			case (i_paddr)
				`PMI_OFF_CONTROL:  next_prdata[3:0] = match_control;
				`PMI_OFF_PATTERN:  next_prdata[WIDTH-1:0] = match_pattern;
				`PMI_OFF_MASK:     next_prdata[WIDTH-1:0] = pin_match_mask;
				`PMI_OFF_STATUS:   next_prdata[1:0] = irq_status;
				`PMI_OFF_IRQ_MASK: next_prdata[1:0] = irq_mask;
				default:           next_prdata = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	// registers only; reset gives the power-on defaults
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			match_pattern  <= `PMI_PATTERN_RST;
			pin_match_mask <= `PMI_MASK_RST;
			match_control  <= `PMI_CONTROL_RST;
			irq_status     <= 2'b00;
			irq_mask       <= `PMI_IRQ_MASK_RST;
			prdata         <= 32'h0000_0000;
			ack            <= 1'b0;
		end else begin
			match_pattern  <= next_match_pattern;
			pin_match_mask <= next_pin_match_mask;
			match_control  <= next_match_control;
			irq_status     <= next_irq_status;
			irq_mask       <= next_irq_mask;
			prdata         <= next_prdata;
			ack            <= next_ack;
		end
	end

	// read data straight from its flop; costs the one wait state
	always_comb begin
		o_prdata = prdata;
	end

	// interrupt outputs; wake is a level usable with clocks stopped elsewhere
	always_comb begin
		o_match_irq = match_flag && flag_irq_enable;
		o_wake      = match_flag && flag_irq_enable;
		o_irq       = |(irq_status & irq_mask);
	end

	a_flag_needs_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
		$rose(match_flag) |-> $past(cond, 1) && $past(cond, 7))
		else $error("flag set without persistent match");
	a_flag_sticky: assert property (@(posedge i_core_clk) disable iff (i_reset)
		match_flag && !(wr && i_paddr == `PMI_OFF_CONTROL) |=> match_flag)
		else $error("flag dropped without software write");
	a_irq_gated: assert property (@(posedge i_core_clk) disable iff (i_reset)
		o_match_irq |-> flag_irq_enable && match_flag)
		else $error("match irq without enable");
	// counted from the start of a run: a clear inside a run is not re-armed
	a_hold_sets: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!cond ##1 cond [*8] |=> match_flag)
		else $error("persistent match did not set flag");
	a_short_ignored: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!match_flag && !cond ##1 cond [*3] ##1 !cond |=> !match_flag)
		else $error("short match set flag");
	a_sense_equal: assert property (@(posedge i_core_clk) disable iff (i_reset)
		unit_enable && !compare_sense_select |-> cond == port_equal)
		else $error("equal sense wrong");
	a_mask_excl: assert property (@(posedge i_core_clk) disable iff (i_reset)
		pin_match_mask == '0 |-> port_equal)
		else $error("masked pins affected compare");
	a_wake_level: assert property (@(posedge i_core_clk) disable iff (i_reset)
		$rose(match_flag) && flag_irq_enable |-> o_wake)
		else $error("no wake on enabled match");

	// ready answers the access one cycle late
	a_ready_wait: assert property (@(posedge i_core_clk) disable iff (i_reset)
		access && !o_pready |=> o_pready)
		else $error("ready did not follow access");
	// ready lasts a single cycle, so no write lands twice
	a_ready_single: assert property (@(posedge i_core_clk) disable iff (i_reset)
		o_pready |=> !o_pready)
		else $error("ready held over two cycles");
	// read word stands between captures
	a_read_stands: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!capture |=> $stable(o_prdata))
		else $error("read data moved outside a capture");
	// a status read clears exactly the bits it returned
	a_status_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
		rd && i_paddr == `PMI_OFF_STATUS && !hit
			|=> (irq_status & o_prdata[1:0]) == 2'b00)
		else $error("status bits survived their read");

	// not-equal sense inverts the compare
	a_sense_noteq: assert property (@(posedge i_core_clk) disable iff (i_reset)
		unit_enable && compare_sense_select |-> cond == !port_equal)
		else $error("not-equal sense wrong");
	// sense and enable change only by a control write
	a_sense_kept: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!(wr && i_paddr == `PMI_OFF_CONTROL)
			|=> $stable(compare_sense_select) && $stable(unit_enable))
		else $error("sense changed without write");
	// nothing is qualified while the unit is off
	a_inactive_quiet: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!unit_enable |-> !cond && !hit)
		else $error("match while unit inactive");
	// a qualified match sets flag and status together
	a_hit_sets: assert property (@(posedge i_core_clk) disable iff (i_reset)
		hit |=> match_flag && irq_status[0])
		else $error("qualified match lost");
	// status event bit only leaves through a read
	a_status_sticky: assert property (@(posedge i_core_clk) disable iff (i_reset)
		irq_status[0] && !rd |=> irq_status[0])
		else $error("status dropped without read");

	// keypad setup: any unmasked low pin counts
	a_keypad_any: assert property (@(posedge i_core_clk) disable iff (i_reset)
		unit_enable && compare_sense_select && (&match_pattern)
			&& (pin_match_mask & ~port_sync) != '0 |-> cond)
		else $error("low key not seen in keypad setup");
	// equal whenever the unmasked bits agree
	a_mask_compare: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(port_sync & pin_match_mask) == (match_pattern & pin_match_mask) |-> port_equal)
		else $error("unmasked agreement not equal");
	// unequal whenever an unmasked bit differs
	a_mask_differ: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(port_sync & pin_match_mask) != (match_pattern & pin_match_mask) |-> !port_equal)
		else $error("unmasked difference missed");
	// mask changes only by its own write
	a_mask_kept: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!(wr && i_paddr == `PMI_OFF_MASK) |=> $stable(pin_match_mask))
		else $error("mask changed without write");
	// pattern changes only by its own write
	a_pattern_kept: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!(wr && i_paddr == `PMI_OFF_PATTERN) |=> $stable(match_pattern))
		else $error("pattern changed without write");

	// one pulse per continuous match
	a_hit_once: assert property (@(posedge i_core_clk) disable iff (i_reset)
		hit |=> !hit)
		else $error("match qualified twice");
	// software can never set the flag
	a_no_soft_set: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!match_flag && !hit |=> !match_flag)
		else $error("flag set without match");
	// writing zero clears unless a match lands at once
	a_flag_clears: assert property (@(posedge i_core_clk) disable iff (i_reset)
		wr && i_paddr == `PMI_OFF_CONTROL && !i_pwdata[`PMI_CTL_FLAG] && !hit
			|=> !match_flag)
		else $error("flag not cleared by zero write");

	// interrupt enable rises only through a control write
	a_enable_kept: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!flag_irq_enable && !(wr && i_paddr == `PMI_OFF_CONTROL) |=> !o_match_irq)
		else $error("match irq without enable write");
	// enabled match raises the request and its status bit
	a_enabled_event: assert property (@(posedge i_core_clk) disable iff (i_reset)
		hit && flag_irq_enable && !wr |=> irq_status[1] && o_match_irq)
		else $error("enabled match gave no request");
	// no wake without the interrupt enable
	a_wake_gated: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!flag_irq_enable |-> !o_wake && !o_match_irq)
		else $error("wake without enable");
	// shared interrupt silent with every source masked
	a_irq_masked: assert property (@(posedge i_core_clk) disable iff (i_reset)
		irq_mask == 2'b00 |-> !o_irq)
		else $error("irq with all sources masked");
endmodule

// File: bench/keypad_model.sv
`timescale 1ns/1ps
// pull-up keypad: a pressed key shorts its pin to ground
module keypad_model (
	input  wire logic [7:0] i_press, // keys held down
	output logic      [7:0] o_pins   // levels seen by the unit
);
	// a released key floats back high through its pull-up, never a stale level
	assign o_pins = ~i_press;
endmodule

// File: bench/port_match_irq_unit_bench.sv
`timescale 1ns/1ps
`include "pmi_consts.svh"
module port_match_irq_unit_bench;
	logic        clk;       // cpu clock
	logic        rst;       // sync reset
	logic        psel;      // apb select
	logic        pen;       // apb enable
	logic        pwr;       // apb direction
	logic [7:0]  paddr;     // apb address
	logic [31:0] pwdata;    // apb write data
	logic [31:0] prdata;    // apb read data
	logic        pready;    // apb ready
	logic        pslverr;   // apb error
	logic [7:0]  press;     // keys held
	logic [7:0]  pins;      // port levels
	logic        mirq;      // match interrupt
	logic        wake;      // wake request
	logic        irq;       // status interrupt
	logic [31:0] rd;        // last read word
	logic        err;       // last error flag
	int          error_cnt; // mismatches
	int          n_tests;   // comparisons

	port_match_irq_unit #(.WIDTH(8)) DUT (
		.i_core_clk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_port_pins(pins),
		.o_match_irq(mirq), .o_wake(wake), .o_irq(irq)
	);
	keypad_model keys (.i_press(press), .o_pins(pins));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// single compare for every result
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd   = prdata;
		err  = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	// hold keys for n cycles, then release and let the sync pipe drain
	task automatic hold_keys(input logic [7:0] k, input int n);
		@(posedge clk);
		press <= k;
		repeat (n) @(posedge clk);
		press <= 8'h00;
		repeat (14) @(posedge clk);
	endtask

	// register reset values and an unmapped write and read
	task automatic t_reset;
		apb(0, `PMI_OFF_CONTROL, 0);  chk("control", 32'h0, rd);
		apb(0, `PMI_OFF_PATTERN, 0);  chk("pattern", 32'hFF, rd);
		apb(0, `PMI_OFF_MASK, 0);     chk("mask", 32'h0, rd);
		apb(0, `PMI_OFF_IRQ_MASK, 0); chk("irq mask", 32'h0, rd);
		apb(1, 8'h40, 32'hFF);        chk("wr slverr", 32'h1, {31'h0, err});
		apb(0, 8'h40, 0);             chk("rd unmapped", 32'h0, rd);
		$display("test reset done");
	endtask

	// keypad mode: all-ones pattern, not-equal, low nibble unmasked
	task automatic t_keypad;
		apb(1, `PMI_OFF_MASK, 32'h0F);  chk("mask slverr", 32'h0, {31'h0, err});
		apb(1, `PMI_OFF_IRQ_MASK, 32'h3);
		apb(1, `PMI_OFF_CONTROL, 32'h0E);
		hold_keys(8'h02, 4);          // too short to count
		apb(0, `PMI_OFF_CONTROL, 0);  chk("short press", 32'h0E, rd);
		hold_keys(8'h02, 12);         // long press, released after
		apb(0, `PMI_OFF_CONTROL, 0);  chk("flag sticky", 32'h0F, rd);
		chk("match irq", 32'h1, {31'h0, mirq});
		chk("wake", 32'h1, {31'h0, wake});
		chk("irq high", 32'h1, {31'h0, irq});
		apb(0, `PMI_OFF_STATUS, 0);   chk("status", 32'h3, rd);
		apb(0, `PMI_OFF_STATUS, 0);   chk("status cleared", 32'h0, rd);
		chk("irq cleared", 32'h0, {31'h0, irq});
		apb(1, `PMI_OFF_CONTROL, 32'h0F); // writing one leaves the flag alone
		apb(0, `PMI_OFF_CONTROL, 0);  chk("flag kept", 32'h0F, rd);
		apb(1, `PMI_OFF_CONTROL, 32'h0E);
		apb(0, `PMI_OFF_CONTROL, 0);  chk("flag clear", 32'h0E, rd);
		chk("match irq off", 32'h0, {31'h0, mirq});
		apb(1, `PMI_OFF_CONTROL, 32'h0F); // a one cannot set a clear flag
		apb(0, `PMI_OFF_CONTROL, 0);  chk("flag no set", 32'h0E, rd);
		hold_keys(8'h80, 12);         // masked key only
		apb(0, `PMI_OFF_CONTROL, 0);  chk("masked key", 32'h0E, rd);
		$display("test keypad done");
	endtask

	// equal sense, full mask, interrupt enable and status mask off
	task automatic t_equal;
		apb(1, `PMI_OFF_CONTROL, 32'h0);   // disable while reprogramming
		apb(1, `PMI_OFF_IRQ_MASK, 32'h0);
		apb(1, `PMI_OFF_PATTERN, 32'hA5);
		apb(0, `PMI_OFF_PATTERN, 0);  chk("pattern wr", 32'hA5, rd);
		apb(1, `PMI_OFF_MASK, 32'hFF);
		apb(1, `PMI_OFF_CONTROL, 32'h04);
		hold_keys(8'h5A, 3);
		apb(0, `PMI_OFF_CONTROL, 0);  chk("eq short", 32'h04, rd);
		hold_keys(8'h5A, 12);         // pins read A5
		apb(0, `PMI_OFF_CONTROL, 0);  chk("eq flag", 32'h05, rd);
		chk("eq no irq", 32'h0, {31'h0, mirq});
		chk("eq irq masked", 32'h0, {31'h0, irq});
		apb(0, `PMI_OFF_STATUS, 0);   chk("eq status", 32'h1, rd);
		$display("test equal done");
	endtask

	// single place where the run ends
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// main sequence
	initial begin
		error_cnt = 0;
		n_tests   = 0;
		rst    = 1'b1;
		psel   = 1'b0;
		pen    = 1'b0;
		pwr    = 1'b0;
		paddr  = 8'h00;
		pwdata = 32'h0;
		press  = 8'h00;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_keypad;
		t_equal;
		report_and_stop;
	end

	// watchdog: tests need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		report_and_stop;
	end
endmodule
